// file: cpc_channel_power_control_regs.sv
`timescale 1ns/1ps
`default_nettype none
module cpc_channel_power_control_regs (
  input  wire logic       CLK_IN,
  input  wire logic       RESET_N_IN,
  input  wire logic [7:0] REG_ADDR_IN,
  input  wire logic [7:0] REG_WDATA_IN,
  input  wire logic       REG_WR_IN,
  input  wire logic       REG_RD_IN,
  output logic [7:0]      REG_RDATA_OUT,
  output logic            REG_RVALID_OUT,
  output logic [3:0]      INPUT_CHAN_POWER_OUT,
  output logic [3:0]      OUTPUT_CHAN_POWER_OUT,
  output logic            RECORD_ACTIVE_OUT,
  output logic            PLAYBACK_ACTIVE_OUT,
  output logic            MIC_BIAS_POWER_OUT,
  output logic            ULTRASOUND_DETECT_ON_OUT,
  output logic            VOICE_DETECT_ON_OUT,
  output logic            ULTRASOUND_GAIN_ALGO_ON_OUT,
  output logic            DYNAMIC_SEPARATE_MOD_CLOCKS_OUT
);
  import cpc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // register storage
  logic [7:0] channel_enable;
  logic [7:0] dynamic_power_config;
  logic [7:0] power_config;
  logic [7:0] power_status;

  // decode results
  logic       wr_channel_enable;
  logic       wr_dynamic_power_config;
  logic       wr_power_config;
  logic [7:0] rd_data;

  // path carriers
  cpc_path_if record_if ();
  cpc_path_if playback_if ();

  ////////////////////////////////////////////////////////////////////////////////
  // address decode and read selection
  cpc_reg_decode u_decode (
    .addr_in                     (REG_ADDR_IN),
    .wr_in                       (REG_WR_IN),
    .channel_enable_in           (channel_enable),
    .dynamic_power_config_in     (dynamic_power_config),
    .power_config_in             (power_config),
    .power_status_in             (power_status),
    .wr_channel_enable_out       (wr_channel_enable),
    .wr_dynamic_power_config_out (wr_dynamic_power_config),
    .wr_power_config_out         (wr_power_config),
    .rd_data_out                 (rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // channel enable register, all bits writable
  always_ff @(posedge CLK_IN)
  begin
    if (!RESET_N_IN)
    begin
      // RULE1 RULE2 enable reset
      channel_enable <= CPC_RST_CHANNEL_ENABLE;
    end
    else if (wr_channel_enable)
    begin
      // RULE18 enables always stored
      channel_enable <= REG_WDATA_IN;
    end
  end

  // dynamic power config register
  always_ff @(posedge CLK_IN)
  begin
    if (!RESET_N_IN)
    begin
      dynamic_power_config <= CPC_RST_DYNAMIC_POWER_CONFIG;
    end
    else if (wr_dynamic_power_config)
    begin
      // RULE11 low bits held zero
      dynamic_power_config <= REG_WDATA_IN & CPC_WMASK_DYNAMIC_POWER_CONFIG;
    end
  end

  // power config register
  always_ff @(posedge CLK_IN)
  begin
    if (!RESET_N_IN)
    begin
      power_config <= CPC_RST_POWER_CONFIG;
    end
    else if (wr_power_config)
    begin
      // RULE15 bits 4 and 0 held zero
      power_config <= REG_WDATA_IN & CPC_WMASK_POWER_CONFIG;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // record path control
  always_comb
  begin
    // RULE1 input enables
    record_if.enable     = channel_enable[CPC_POS_INPUT_CHAN_MSB:CPC_POS_INPUT_CHAN_LSB];
    // RULE3 record gate
    record_if.path_power = power_config[CPC_POS_RECORD_PATH_POWER];
    // RULE6 record dynamic
    record_if.dynamic    = dynamic_power_config[CPC_POS_RECORD_DYNAMIC_POWER];
    // RULE8 record range
    record_if.four_chan  = dynamic_power_config[CPC_POS_RECORD_DYNAMIC_FOUR_CHAN];
  end

  // playback path control
  always_comb
  begin
    // RULE2 output enables
    playback_if.enable     = channel_enable[CPC_POS_OUTPUT_CHAN_MSB:CPC_POS_OUTPUT_CHAN_LSB];
    // RULE4 playback gate
    playback_if.path_power = power_config[CPC_POS_PLAYBACK_PATH_POWER];
    // RULE7 playback dynamic
    playback_if.dynamic    = dynamic_power_config[CPC_POS_PLAYBACK_DYNAMIC_POWER];
    // RULE9 playback range
    playback_if.four_chan  = dynamic_power_config[CPC_POS_PLAYBACK_DYNAMIC_FOUR_CHAN];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one power sequencer per path
  cpc_path_power u_record (
    .clk_in     (CLK_IN),
    .reset_n_in (RESET_N_IN),
    .pif        (record_if.path)
  );

  cpc_path_power u_playback (
    .clk_in     (CLK_IN),
    .reset_n_in (RESET_N_IN),
    .pif        (playback_if.path)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // live power status of every channel
  always_ff @(posedge CLK_IN)
  begin
    if (!RESET_N_IN)
    begin
      power_status <= CPC_RST_POWER_STATUS;
    end
    else
    begin
      // RULE16 RULE17 channel power status
      power_status <= {record_if.powered, playback_if.powered};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read answer, registered one cycle after the read strobe
  always_ff @(posedge CLK_IN)
  begin
    if (!RESET_N_IN)
    begin
      REG_RDATA_OUT <= CPC_UNMAPPED_READ;
    end
    else if (REG_RD_IN)
    begin
      REG_RDATA_OUT <= rd_data;
    end
  end

  // read valid pulse
  always_ff @(posedge CLK_IN)
  begin
    if (!RESET_N_IN)
    begin
      REG_RVALID_OUT <= 1'b0;
    end
    else
    begin
      REG_RVALID_OUT <= REG_RD_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // channel power and activity outputs, straight from sequencer flops
  always_comb
  begin
    INPUT_CHAN_POWER_OUT  = record_if.powered;
    OUTPUT_CHAN_POWER_OUT = playback_if.powered;
    RECORD_ACTIVE_OUT     = record_if.active;
    PLAYBACK_ACTIVE_OUT   = playback_if.active;
  end

  // analog and algorithm controls, straight from register flops
  always_comb
  begin
    // RULE5 mic bias
    MIC_BIAS_POWER_OUT              = power_config[CPC_POS_MIC_BIAS_POWER];
    // RULE12 ultrasound detect
    ULTRASOUND_DETECT_ON_OUT        = power_config[CPC_POS_ULTRASOUND_DETECT_ON];
    // RULE13 voice detect
    VOICE_DETECT_ON_OUT             = power_config[CPC_POS_VOICE_DETECT_ON];
    // RULE14 gain algorithm
    ULTRASOUND_GAIN_ALGO_ON_OUT     = power_config[CPC_POS_ULTRASOUND_GAIN_ALGO_ON];
    // RULE10 clock scheme select
    DYNAMIC_SEPARATE_MOD_CLOCKS_OUT = dynamic_power_config[CPC_POS_DYNAMIC_SEPARATE_MOD_CLOCKS];
  end

endmodule // cpc_channel_power_control_regs
`default_nettype wire

// file: cpc_pkg.sv
// What this block does
// RULE1: channel enable bits 7..4 turn input channels 1..4 on; 1 and 2 reset on
// RULE2: channel enable bits 3..0 turn output channels 1..4 on; 1 and 2 reset on
// RULE3: power config bit 7 clear powers all record channels down, set powers enabled ones
// RULE4: power config bit 6 clear powers all playback channels down, set powers enabled ones
// RULE5: power config bit 5 drives microphone bias power; resets to zero
// RULE6: record dynamic bit clear freezes record channel power while recording is active
// RULE7: playback dynamic bit clear freezes playback channel power while playback is active
// RULE8: record dynamic bit 6 selects channels 1-2 or 1-4 as dynamically managed
// RULE9: playback dynamic bit 4 selects channels 1-2 or 1-4 as dynamically managed
// RULE10: dynamic config bit 3 selects shared or separate modulator and pdm clocks
// RULE11: dynamic config bits 2..0 read zero; software writes only zero there
// RULE12: power config bit 3 turns ultrasound activity detection on; resets to zero
// RULE13: power config bit 2 turns voice activity detection on; resets to zero
// RULE14: power config bit 1 turns ultrasound gain algorithm on; resets to zero
// RULE15: power config bits 4 and 0 read zero; software writes only zero there
// RULE16: status shows per input channel whether it is really powered up
// RULE17: status shows per output channel whether it is really powered up
// RULE18: frozen path stores enable changes and applies them at next path power-up
package cpc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] CPC_OFS_CHANNEL_ENABLE       = 8'h76;
  localparam logic [7:0] CPC_OFS_DYNAMIC_POWER_CONFIG = 8'h77;
  localparam logic [7:0] CPC_OFS_POWER_CONFIG         = 8'h78;
  localparam logic [7:0] CPC_OFS_POWER_STATUS         = 8'h79;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] CPC_RST_CHANNEL_ENABLE       = 8'hcc;
  localparam logic [7:0] CPC_RST_DYNAMIC_POWER_CONFIG = 8'h00;
  localparam logic [7:0] CPC_RST_POWER_CONFIG         = 8'h00;
  localparam logic [7:0] CPC_RST_POWER_STATUS         = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // channel enable fields (msb of each nibble is channel 1)
  localparam int CPC_POS_INPUT_CHAN_MSB  = 7;
  localparam int CPC_POS_INPUT_CHAN_LSB  = 4;
  localparam int CPC_POS_OUTPUT_CHAN_MSB = 3;
  localparam int CPC_POS_OUTPUT_CHAN_LSB = 0;

  // dynamic power config fields
  localparam int CPC_POS_RECORD_DYNAMIC_POWER        = 7;
  localparam int CPC_POS_RECORD_DYNAMIC_FOUR_CHAN    = 6;
  localparam int CPC_POS_PLAYBACK_DYNAMIC_POWER      = 5;
  localparam int CPC_POS_PLAYBACK_DYNAMIC_FOUR_CHAN  = 4;
  localparam int CPC_POS_DYNAMIC_SEPARATE_MOD_CLOCKS = 3;
  localparam logic [7:0] CPC_WMASK_DYNAMIC_POWER_CONFIG = 8'hf8;

  // power config fields
  localparam int CPC_POS_RECORD_PATH_POWER       = 7;
  localparam int CPC_POS_PLAYBACK_PATH_POWER     = 6;
  localparam int CPC_POS_MIC_BIAS_POWER          = 5;
  localparam int CPC_POS_ULTRASOUND_DETECT_ON    = 3;
  localparam int CPC_POS_VOICE_DETECT_ON         = 2;
  localparam int CPC_POS_ULTRASOUND_GAIN_ALGO_ON = 1;
  localparam logic [7:0] CPC_WMASK_POWER_CONFIG = 8'hee;

  ////////////////////////////////////////////////////////////////////////////////
  // dynamically managed channel sets within a nibble
  localparam logic [3:0] CPC_DYN_PAIR_MASK = 4'hc;
  localparam logic [3:0] CPC_DYN_ALL_MASK  = 4'hf;

  // read answer for unmapped offsets
  localparam logic [7:0] CPC_UNMAPPED_READ = 8'h00;

  // per path power state
  typedef enum logic [1:0] {
    CPC_PATH_OFF,
    CPC_PATH_IDLE,
    CPC_PATH_ACTIVE
  } cpc_path_state_t;

endpackage

// file: cpc_path_if.sv
`timescale 1ns/1ps
`default_nettype none
// control and status of one record or playback path
interface cpc_path_if;
  logic       path_power;
  logic       dynamic;
  logic       four_chan;
  logic [3:0] enable;
  logic [3:0] powered;
  logic       active;

  modport ctrl (
    output path_power,
    output dynamic,
    output four_chan,
    output enable,
    input  powered,
    input  active
  );

  modport path (
    input  path_power,
    input  dynamic,
    input  four_chan,
    input  enable,
    output powered,
    output active
  );
endinterface
`default_nettype wire

// file: cpc_path_power.sv
`timescale 1ns/1ps
`default_nettype none
module cpc_path_power (
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  cpc_path_if.path  pif
);
  import cpc_pkg::*;

  cpc_path_state_t state;
  cpc_path_state_t next_state;
  logic [3:0]      next_powered;
  logic [3:0]      dyn_set;

  ////////////////////////////////////////////////////////////////////////////////
  // channels that may follow their enable while the path runs
  always_comb
  begin
    // RULE8 RULE9 channel set
    dyn_set = pif.four_chan ? CPC_DYN_ALL_MASK : CPC_DYN_PAIR_MASK;
  end

  // next channel power and path state
  always_comb
  begin
    next_powered = pif.powered;
    next_state   = state;
    unique case (state)
      CPC_PATH_OFF,
      CPC_PATH_IDLE:
      begin
        // RULE3 RULE4 path power gate
        if (pif.path_power)
        begin
          next_powered = pif.enable;
        end
        else
        begin
          next_powered = 4'h0;
        end
      end
      CPC_PATH_ACTIVE:
      begin
        if (!pif.path_power)
        begin
          next_powered = 4'h0;
        end
        // RULE6 RULE7 RULE18 hold while active
        else if (pif.dynamic)
        begin
          next_powered = (pif.enable & dyn_set) | (pif.powered & ~dyn_set);
        end
      end
    endcase
    if (!pif.path_power)
    begin
      next_state = CPC_PATH_OFF;
    end
    else if (|next_powered)
    begin
      next_state = CPC_PATH_ACTIVE;
    end
    else
    begin
      next_state = CPC_PATH_IDLE;
    end
  end

  // state and channel power flops
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      state       <= CPC_PATH_OFF;
      pif.powered <= 4'h0;
    end
    else
    begin
      state       <= next_state;
      pif.powered <= next_powered;
    end
  end

  assign pif.active = (state == CPC_PATH_ACTIVE);

endmodule // cpc_path_power
`default_nettype wire

// file: cpc_reg_decode.sv
`timescale 1ns/1ps
`default_nettype none
module cpc_reg_decode (
  input  wire logic [7:0] addr_in,
  input  wire logic       wr_in,
  input  wire logic [7:0] channel_enable_in,
  input  wire logic [7:0] dynamic_power_config_in,
  input  wire logic [7:0] power_config_in,
  input  wire logic [7:0] power_status_in,
  output logic            wr_channel_enable_out,
  output logic            wr_dynamic_power_config_out,
  output logic            wr_power_config_out,
  output logic [7:0]      rd_data_out
);
  import cpc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // write strobes per register; status is read only
  always_comb
  begin
    wr_channel_enable_out       = wr_in && (addr_in == CPC_OFS_CHANNEL_ENABLE);
    wr_dynamic_power_config_out = wr_in && (addr_in == CPC_OFS_DYNAMIC_POWER_CONFIG);
    wr_power_config_out         = wr_in && (addr_in == CPC_OFS_POWER_CONFIG);
  end

  // read selection, unmapped offsets answer zero
  always_comb
  begin
    unique case (addr_in)
      CPC_OFS_CHANNEL_ENABLE:       rd_data_out = channel_enable_in;
      CPC_OFS_DYNAMIC_POWER_CONFIG: rd_data_out = dynamic_power_config_in;
      CPC_OFS_POWER_CONFIG:         rd_data_out = power_config_in;
      CPC_OFS_POWER_STATUS:         rd_data_out = power_status_in;
      default:                      rd_data_out = CPC_UNMAPPED_READ;
    endcase
  end

endmodule // cpc_reg_decode
`default_nettype wire

// file: cpc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cpc_monitor (
  input wire logic       CLK_IN,
  input wire logic       RESET_N_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic       REG_WR_IN,
  input wire logic       REG_RD_IN,
  input wire logic [7:0] REG_RDATA_OUT,
  input wire logic       REG_RVALID_OUT,
  input wire logic [3:0] INPUT_CHAN_POWER_OUT,
  input wire logic [3:0] OUTPUT_CHAN_POWER_OUT,
  input wire logic       RECORD_ACTIVE_OUT,
  input wire logic       PLAYBACK_ACTIVE_OUT,
  input wire logic       MIC_BIAS_POWER_OUT,
  input wire logic       ULTRASOUND_DETECT_ON_OUT,
  input wire logic       VOICE_DETECT_ON_OUT,
  input wire logic       ULTRASOUND_GAIN_ALGO_ON_OUT,
  input wire logic       DYNAMIC_SEPARATE_MOD_CLOCKS_OUT
);
  logic [7:0] en_q;
  logic [7:0] dyn_q;
  logic       wr77;
  logic       wr78;
  ////////////////////////////////////////
  // write decode seen at the register port
  assign wr77 = REG_WR_IN && (REG_ADDR_IN == 8'h77);
  assign wr78 = REG_WR_IN && (REG_ADDR_IN == 8'h78);

  // mirror of enable and dynamic settings
  always_ff @(posedge CLK_IN)
  begin
    if (!RESET_N_IN)
    begin
      en_q  <= 8'hcc;
      dyn_q <= 8'h00;
    end
    else
    begin
      if (REG_WR_IN && (REG_ADDR_IN == 8'h76)) en_q <= REG_WDATA_IN;
      if (wr77) dyn_q <= REG_WDATA_IN;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  // single power config write, then quiet
  sequence pwr_wr;
    wr78 ##1 !wr78;
  endsequence
  // record path running with dynamic mode off
  sequence rec_frozen;
    (RECORD_ACTIVE_OUT && !dyn_q[7] && !wr78 && !wr77) ##1 (!wr78 && !wr77);
  endsequence
  // record gate set while the path is not active
  sequence rec_wake;
    (wr78 && REG_WDATA_IN[7] && !RECORD_ACTIVE_OUT) ##1 !REG_WR_IN;
  endsequence
  // playback path running with dynamic mode off
  sequence pb_frozen;
    (PLAYBACK_ACTIVE_OUT && !dyn_q[5] && !wr78 && !wr77) ##1 (!wr78 && !wr77);
  endsequence
  // playback gate set while the path is not active
  sequence pb_wake;
    (wr78 && REG_WDATA_IN[6] && !PLAYBACK_ACTIVE_OUT) ##1 !REG_WR_IN;
  endsequence

  read_valid_a:
    assert property (REG_RD_IN |=> REG_RVALID_OUT) else $error("read answer missing");
  no_spurious_a:
    assert property (!REG_RD_IN |=> !REG_RVALID_OUT) else $error("read answer without read");
  rdata_hold_a:
    assert property (!REG_RD_IN |=> $stable(REG_RDATA_OUT)) else $error("read data moved");
  bias_follow_a:
    assert property (pwr_wr |-> ##1 (MIC_BIAS_POWER_OUT == $past(REG_WDATA_IN[5], 2)))
      else $error("bias power wrong");
  algo_bits_a:
    assert property (pwr_wr |-> ##1 ({ULTRASOUND_DETECT_ON_OUT, VOICE_DETECT_ON_OUT,
      ULTRASOUND_GAIN_ALGO_ON_OUT} == $past(REG_WDATA_IN[3:1], 2))) else $error("algo bits wrong");
  sep_clock_a:
    assert property ((wr77 ##1 !wr77) |-> ##1
      (DYNAMIC_SEPARATE_MOD_CLOCKS_OUT == $past(REG_WDATA_IN[3], 2))) else $error("clock select wrong");
  record_off_a:
    assert property (((wr78 && !REG_WDATA_IN[7]) ##1 !wr78) |-> ##1 (INPUT_CHAN_POWER_OUT == 4'h0))
      else $error("record channels not off");
  playback_off_a:
    assert property (((wr78 && !REG_WDATA_IN[6]) ##1 !wr78) |-> ##1 (OUTPUT_CHAN_POWER_OUT == 4'h0))
      else $error("playback channels not off");
  record_on_a:
    assert property (rec_wake |-> ##1 (INPUT_CHAN_POWER_OUT == en_q[7:4]))
      else $error("record channels not per enables");
  rec_freeze_a:
    assert property (rec_frozen |=> $stable(INPUT_CHAN_POWER_OUT)) else $error("frozen path moved");
  pb_freeze_a:
    assert property (pb_frozen |=> $stable(OUTPUT_CHAN_POWER_OUT))
      else $error("frozen playback moved");
  playback_on_a:
    assert property (pb_wake |-> ##1 (OUTPUT_CHAN_POWER_OUT == en_q[3:0]))
      else $error("playback channels not per enables");
  reserved_zero_a:
    assert property ((REG_RD_IN && (REG_ADDR_IN == 8'h77 || REG_ADDR_IN == 8'h78)) |=>
      ((REG_RDATA_OUT & (($past(REG_ADDR_IN) == 8'h77) ? 8'h07 : 8'h11)) == 8'h00))
      else $error("reserved bits not zero");
endmodule // cpc_monitor

bind cpc_channel_power_control_regs cpc_monitor i_mon (.*);
`default_nettype wire

// file: cpc_channel_power_control_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cpc_channel_power_control_regs_tb;
  import cpc_pkg::*;
  logic       clk;
  logic       reset_n;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       rvalid;
  logic [3:0] in_pwr;
  logic [3:0] out_pwr;
  logic       bias;
  logic       uad;
  logic       vad;
  logic       uag;
  logic       sep;
  logic       rec_act;
  logic       pb_act;
  logic [7:0] exp_q[$];
  logic [7:0] e;
  int         error_cnt;
  int         n_compared;
  int         i;

  cpc_channel_power_control_regs i_dut (
    .CLK_IN(clk), .RESET_N_IN(reset_n), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
    .INPUT_CHAN_POWER_OUT(in_pwr), .OUTPUT_CHAN_POWER_OUT(out_pwr),
    .RECORD_ACTIVE_OUT(rec_act), .PLAYBACK_ACTIVE_OUT(pb_act),
    .MIC_BIAS_POWER_OUT(bias), .ULTRASOUND_DETECT_ON_OUT(uad),
    .VOICE_DETECT_ON_OUT(vad), .ULTRASOUND_GAIN_ALGO_ON_OUT(uag),
    .DYNAMIC_SEPARATE_MOD_CLOCKS_OUT(sep)
  );
  ////////////////////////////////////////
  // clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // compare and count
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one register access; a read notes its expected answer
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wdata = d;
    wr = w;
    rd = !w;
    if (!w)
      exp_q.push_back(d);
    @(posedge clk);
    #1;
    wr = 1'b0;
    rd = 1'b0;
  endtask

  // let power sequencing and status land
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask

  // channel power outputs and status register
  task automatic stat(input logic [7:0] x);
    settle();
    chk("chan_power", {in_pwr, out_pwr}, x);
    chk("path_active", {6'h0, rec_act, pb_act}, {6'h0, |x[7:4], |x[3:0]});
    acc(1'b0, CPC_OFS_POWER_STATUS, x);
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////
  // read answers checked against oldest note, half a cycle after they launch
  always @(negedge clk)
  begin
    if (rvalid === 1'b1)
      chk("read_data", rdata, exp_q.pop_front());
  end

  // main sequence
  initial
  begin
    error_cnt = 0;
    n_compared = 0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    reset_n = 1'b0;
    void'($urandom(44022));
    repeat (4) @(posedge clk);
    #1;
    reset_n = 1'b1;
    acc(1'b0, CPC_OFS_CHANNEL_ENABLE, 8'hcc);
    acc(1'b0, CPC_OFS_DYNAMIC_POWER_CONFIG, 8'h00);
    acc(1'b0, CPC_OFS_POWER_CONFIG, 8'h00);
    acc(1'b0, 8'h75, CPC_UNMAPPED_READ);
    stat(8'h00);
    $display("test reset done");
    // reserved positions are written with zero only
    acc(1'b1, CPC_OFS_DYNAMIC_POWER_CONFIG, 8'hf8);
    acc(1'b1, CPC_OFS_POWER_CONFIG, 8'hee);
    acc(1'b1, CPC_OFS_POWER_STATUS, 8'h55);
    acc(1'b0, CPC_OFS_DYNAMIC_POWER_CONFIG, 8'hf8);
    acc(1'b0, CPC_OFS_POWER_CONFIG, 8'hee);
    stat(8'hcc);
    chk("ctrl_bits", {3'h0, bias, uad, vad, uag, sep}, 8'h1f);
    acc(1'b1, CPC_OFS_POWER_CONFIG, 8'h00);
    acc(1'b1, CPC_OFS_DYNAMIC_POWER_CONFIG, 8'h00);
    stat(8'h00);
    chk("ctrl_bits", {3'h0, bias, uad, vad, uag, sep}, 8'h00);
    $display("test reserved done");
    for (i = 0; i < 8; i++)
    begin
      e = 8'($urandom());
      acc(1'b1, CPC_OFS_CHANNEL_ENABLE, e);
      acc(1'b0, CPC_OFS_CHANNEL_ENABLE, e);
      acc(1'b1, CPC_OFS_POWER_CONFIG, e & 8'h2e);
      acc(1'b0, CPC_OFS_POWER_CONFIG, e & 8'h2e);
      settle();
      chk("ctrl_bits", {4'h0, bias, uad, vad, uag}, {4'h0, e[5], e[3:1]});
    end
    stat(8'h00);
    acc(1'b1, CPC_OFS_POWER_CONFIG, 8'hc0);
    stat(e);
    $display("test random done");
    acc(1'b1, CPC_OFS_POWER_CONFIG, 8'h00);
    acc(1'b1, CPC_OFS_CHANNEL_ENABLE, 8'hcc);
    acc(1'b1, CPC_OFS_POWER_CONFIG, 8'hc0);
    stat(8'hcc);
    acc(1'b1, CPC_OFS_CHANNEL_ENABLE, 8'hff);
    stat(8'hcc);
    acc(1'b1, CPC_OFS_POWER_CONFIG, 8'h00);
    acc(1'b1, CPC_OFS_POWER_CONFIG, 8'hc0);
    stat(8'hff);
    $display("test freeze done");
    acc(1'b1, CPC_OFS_POWER_CONFIG, 8'h00);
    acc(1'b1, CPC_OFS_CHANNEL_ENABLE, 8'hcc);
    acc(1'b1, CPC_OFS_POWER_CONFIG, 8'hc0);
    stat(8'hcc);
    acc(1'b1, CPC_OFS_DYNAMIC_POWER_CONFIG, 8'ha0);
    acc(1'b1, CPC_OFS_CHANNEL_ENABLE, 8'h77);
    stat(8'h44);
    acc(1'b1, CPC_OFS_DYNAMIC_POWER_CONFIG, 8'hf0);
    stat(8'h77);
    acc(1'b1, CPC_OFS_POWER_CONFIG, 8'h00);
    stat(8'h00);
    $display("test dynamic done");
    for (i = 0; i < 10 && exp_q.size() != 0; i++)
      @(posedge clk);
    if (exp_q.size() != 0)
      error_cnt++;
    end_sim();
  end
endmodule // cpc_channel_power_control_regs_tb
`default_nettype wire
